//--- logic/slcd_ctrl.sv
// Purpose: Segment display controller: registers, clocking, frame sequencing.
// Assumes: APB slave, one wait state; analog divider and glass are outside.
// Notes:   Common and segment outputs are digital selects for the drivers.
//
// What this block does
// - Set the frame-start flag when the last common of an even frame begins.
// - Request interrupt only while flag is set and its enable is set.
// - Writing one to the clear bit clears the flag; clear bit reads zero.
// - Flash select chooses none, pixel 0/0, segment 0 all commons, or all pixels.
// - Flash rate divides frame base by 8 doubling up to 1024.
// - Multiplex field picks static, 1/2, 1/3, 1/4 duty; eighth-duty bit forces 1/8.
// - Half-bias bit picks 1/3 or 1/2 bias when quarter bias is off.
// - Quarter-bias bit selects 1/4 bias; software keeps half-bias at zero.
// - Each level change turns on strong drive for pulse-length prescaled cycles.
// - Strong drive pulse never exceeds half a frame base period.
// - Strong hold keeps the low-resistance divider on permanently.
// - A new contrast code takes effect only at the next frame start.
// - Supply source bit picks internal or external panel supply.
// - Clearing display enable mid-frame stops only at end of even frame.
// - Insert blank phases, 0 to 7, between frames with all levels zero.
// - Prescaled clock is input clock divided by two to the power divider.
// - Frame base period is fine divider plus 16 prescaled cycles.
// - Pin mask bit one makes pin a segment driver, zero leaves it GPIO.
// - Page select maps pixel window to commons 0-3 or 4-7.
// - Reserved bits of control three and four read as zero.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module slcd_ctrl
    import slcd_pkg::*;
(
    // APB clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Power mode
    input  wire logic                 halt_mode,
    // Interrupt and wake
    output logic                      irq,
    output logic                      wake_request,
    // Panel drive
    output logic      [7:0]           com_active,
    output logic      [SEG_COUNT-1:0] seg_data,
    output logic      [SEG_COUNT-1:0] seg_enable,
    output logic                      strong_drive,
    output logic      [1:0]           bias_sel,
    output logic      [2:0]           contrast_out,
    output logic                      supply_external,
    output logic                      display_on
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_one, ctrl_two, ctrl_three, clk_sel, ctrl_four;
    logic [7:0]  pin_mask [0:5];
    logic [7:0]  pix_mem  [0:2*PIX_BYTES-1];
    logic        frame_flag;
    slcd_state_t state;
    logic [2:0]  com_idx;
    logic        odd_frame;
    logic [2:0]  blank_cnt;
    logic [15:0] ps_cnt;
    logic [4:0]  fine_cnt;
    logic [9:0]  blink_cnt;
    logic [3:0]  pulse_cnt;
    logic        run;

    // APB decode
    logic       acc;
    logic       wr;
    logic [5:0] idx;
    logic       pix_hit;
    logic       mask_hit;
    logic       mapped;
    logic [5:0] pix_addr;
    assign acc      = psel & penable & pready;
    assign wr       = acc & pwrite;
    assign idx      = paddr[7:2];
    assign pix_hit  = (idx >= IDX_PIX_FIRST) && (idx <= IDX_PIX_LAST);
    assign mask_hit = (idx >= IDX_MASK_FIRST) && (idx <= IDX_MASK_LAST);
    // Unaligned byte addresses are refused like unmapped ones
    assign mapped   = (pix_hit | mask_hit | (idx == IDX_CTRL_ONE) | (idx == IDX_CTRL_TWO)
                    | (idx == IDX_CTRL_THREE) | (idx == IDX_CLK_SEL) | (idx == IDX_CTRL_FOUR))
                    & (paddr[1:0] == 2'h0);
    // Page bit selects which half of the pixel array the window reaches
    assign pix_addr = ctrl_four[POS_PAGE] ? (idx - IDX_PIX_FIRST + 6'(PIX_BYTES)) : (idx - IDX_PIX_FIRST);

    // Control fields
    logic [1:0] flash_sel;
    logic [2:0] flash_rate;
    logic [2:0] pulse_len;
    logic [2:0] blank_phases;
    logic [3:0] pwr_div;
    logic [3:0] fine_div;
    logic [2:0] last_com;
    assign flash_sel    = ctrl_one[POS_FLASH_SEL +: 2];
    assign flash_rate   = ctrl_one[POS_FLASH_RATE +: 3];
    assign pulse_len    = ctrl_two[POS_PULSE_LEN +: 3];
    assign blank_phases = ctrl_three[POS_BLANK +: 3];
    assign pwr_div      = clk_sel[POS_PWR_DIV +: 4];
    assign fine_div     = clk_sel[POS_FINE_DIV +: 4];

    // Last common index from the duty selection
    always_comb begin
        if (ctrl_four[POS_EIGHTH]) begin
            last_com = 3'h7;
        end else begin
            last_com = {1'b0, ctrl_one[POS_MUX_RATIO +: 2]};
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------------
    // Answer phase with read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite && mapped) begin
                if (pix_hit) begin
                    prdata[7:0] <= pix_mem[pix_addr];
                end else if (mask_hit) begin
                    prdata[7:0] <= pin_mask[3'(idx - IDX_MASK_FIRST)];
                end else begin
                    unique case (idx)
                        IDX_CTRL_ONE:   prdata[7:0] <= ctrl_one;
                        IDX_CTRL_TWO:   prdata[7:0] <= ctrl_two;
                        IDX_CTRL_THREE: prdata[7:0] <= (ctrl_three & CTRL3_RW_MASK)
                                                       | (8'(frame_flag) << POS_FLAG);
                        IDX_CLK_SEL:    prdata[7:0] <= clk_sel;
                        default:        prdata[7:0] <= ctrl_four & CTRL4_RW_MASK;
                    endcase
                end
            end
        end
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one   <= REG_RESET;
            ctrl_two   <= REG_RESET;
            ctrl_three <= REG_RESET;
            clk_sel    <= REG_RESET;
            ctrl_four  <= REG_RESET;
        end else if (wr && paddr[1:0] == 2'h0) begin
            if (idx == IDX_CTRL_ONE)   ctrl_one   <= pwdata[7:0];
            if (idx == IDX_CTRL_TWO)   ctrl_two   <= pwdata[7:0];
            if (idx == IDX_CTRL_THREE) ctrl_three <= pwdata[7:0] & CTRL3_RW_MASK;
            if (idx == IDX_CLK_SEL)    clk_sel    <= pwdata[7:0];
            if (idx == IDX_CTRL_FOUR)  ctrl_four  <= pwdata[7:0] & CTRL4_RW_MASK;
        end
    end

    // Pin masks and pixel memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 6; i++) pin_mask[i] <= REG_RESET;
            for (int i = 0; i < 2*PIX_BYTES; i++) pix_mem[i] <= REG_RESET;
        end else if (wr && paddr[1:0] == 2'h0) begin
            if (mask_hit) begin
                pin_mask[3'(idx - IDX_MASK_FIRST)] <= (idx == IDX_MASK_LAST) ? (pwdata[7:0] & MASK5_RW_MASK)
                                                                             : pwdata[7:0];
            end
            if (pix_hit) begin
                pix_mem[pix_addr] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------------
    logic [15:0] ps_mask;
    logic        ps_tick;
    logic        fb_tick;
    assign ps_mask = (16'h0001 << pwr_div) - 16'h0001;
    assign ps_tick = ((ps_cnt | ~ps_mask) == 16'hFFFF);
    assign fb_tick = ps_tick && (fine_cnt == 5'(FINE_BASE + {2'h0, fine_div} - 6'h01));

    // Prescaler and fine divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_cnt   <= 16'h0000;
            fine_cnt <= 5'h00;
        end else if (!halt_mode) begin
            ps_cnt <= ps_cnt + 16'h0001;
            if (fb_tick) begin
                fine_cnt <= 5'h00;
            end else if (ps_tick) begin
                fine_cnt <= fine_cnt + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    slcd_state_t next_state;
    logic [2:0]  next_com;
    logic        next_odd;
    logic        new_frame;
    always_comb begin
        next_state = state;
        next_com   = com_idx;
        next_odd   = odd_frame;
        new_frame  = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (run) begin
                    next_state = ST_ACTIVE;
                    next_com   = 3'h0;
                    next_odd   = 1'b0;
                    new_frame  = 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (com_idx >= last_com) begin
                    if (!odd_frame && !ctrl_three[POS_DISP_EN]) begin
                        next_state = ST_IDLE;
                    end else if (blank_phases != 3'h0) begin
                        next_state = ST_BLANK;
                    end else begin
                        next_com  = 3'h0;
                        next_odd  = ~odd_frame;
                        new_frame = 1'b1;
                    end
                end else begin
                    next_com = com_idx + 3'h1;
                end
            end
            ST_BLANK: begin
                if (blank_cnt + 3'h1 >= blank_phases) begin
                    next_state = ST_ACTIVE;
                    next_com   = 3'h0;
                    next_odd   = ~odd_frame;
                    new_frame  = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer state, advanced once per frame base period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            com_idx   <= 3'h0;
            odd_frame <= 1'b0;
            blank_cnt <= 3'h0;
        end else if (fb_tick && !halt_mode) begin
            state     <= next_state;
            com_idx   <= next_com;
            odd_frame <= next_odd;
            blank_cnt <= (state == ST_BLANK) ? blank_cnt + 3'h1 : 3'h0;
        end
    end

    // Run request: follows the display enable bit at once; the sequencer stops only at an even frame end
    assign run = ctrl_three[POS_DISP_EN];

    // Start of frame flag, set wins over clear
    logic sof_event;
    assign sof_event = fb_tick && !halt_mode && (next_state == ST_ACTIVE) && (next_com == last_com)
                       && !next_odd && (new_frame || (com_idx != next_com));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_flag <= 1'b0;
        end else if (sof_event) begin
            frame_flag <= 1'b1;
        end else if (wr && idx == IDX_CTRL_THREE && paddr[1:0] == 2'h0 && pwdata[POS_CLEAR]) begin
            frame_flag <= 1'b0;
        end
    end

    // Interrupt level and wake request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq          <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            irq          <= frame_flag & ctrl_three[POS_IRQ_EN];
            wake_request <= frame_flag & ctrl_three[POS_IRQ_EN] & ~halt_mode;
        end
    end

    // ------------------------------------------------------------------
    // Strong drive pulse
    // ------------------------------------------------------------------
    logic [3:0] half_fb;
    logic [3:0] pulse_load;
    assign half_fb    = 4'((FINE_BASE + {2'h0, fine_div}) >> 1);
    assign pulse_load = ({1'b0, pulse_len} > half_fb) ? half_fb : {1'b0, pulse_len};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt <= 4'h0;
        end else if (fb_tick && !halt_mode && (state != ST_IDLE || next_state != ST_IDLE)) begin
            pulse_cnt <= pulse_load;
        end else if (ps_tick && pulse_cnt != 4'h0 && !halt_mode) begin
            pulse_cnt <= pulse_cnt - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Blink and panel outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 10'h000;
        end else if (fb_tick && !halt_mode) begin
            blink_cnt <= blink_cnt + 10'h001;
        end
    end

    logic             blink_dark;
    logic [111:0]     low_rows;
    logic [SEG_COUNT-1:0] row_bits;
    logic [SEG_COUNT-1:0] flash_mask;
    logic [5:0]       base;
    // Bit index reaches 9, so it needs four bits
    assign blink_dark = blink_cnt[{1'b0, flash_rate} + 4'h2];
    // Page base plus byte offset reaches 43, so six bits
    assign base       = com_idx[2] ? 6'(PIX_BYTES) : 6'h00;
    always_comb begin
        low_rows = '0;
        for (int b = 0; b < 14; b++) begin
            low_rows[b*8 +: 8] = pix_mem[base + 6'(b)];
        end
        row_bits = {pix_mem[base + 6'(15 + 2*com_idx[1:0])],
                    pix_mem[base + 6'(14 + 2*com_idx[1:0])],
                    low_rows[28*com_idx[1:0] +: 28]};
        flash_mask = '0;
        unique case (flash_sel)
            2'h0: flash_mask = '0;
            2'h1: flash_mask[0] = (com_idx == 3'h0);
            2'h2: flash_mask[0] = 1'b1;
            2'h3: flash_mask = '1;
        endcase
    end

    // Registered panel drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_active      <= 8'h00;
            seg_data        <= '0;
            seg_enable      <= '0;
            strong_drive    <= 1'b0;
            bias_sel        <= BIAS_THIRD;
            contrast_out    <= 3'h0;
            supply_external <= 1'b0;
            display_on      <= 1'b0;
        end else begin
            if (state == ST_ACTIVE) begin
                com_active <= 8'h01 << com_idx;
                seg_data   <= row_bits & ~(flash_mask & {SEG_COUNT{blink_dark}}) & seg_enable;
            end else begin
                com_active <= 8'h00;
                seg_data   <= '0;
            end
            seg_enable      <= {pin_mask[5][3:0], pin_mask[4], pin_mask[3],
                                pin_mask[2], pin_mask[1], pin_mask[0]};
            strong_drive    <= ctrl_two[POS_STRONG] | (pulse_cnt != 4'h0);
            if (ctrl_four[POS_QUARTER]) begin
                bias_sel <= BIAS_QUARTER;
            end else begin
                bias_sel <= ctrl_one[POS_HALF_BIAS] ? BIAS_HALF : BIAS_THIRD;
            end
            if (fb_tick && new_frame && !halt_mode) begin
                contrast_out <= ctrl_two[POS_CONTRAST +: 3];
            end
            supply_external <= ctrl_two[POS_SUPPLY];
            display_on      <= (state != ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_irq_level: assert property (##1 irq == $past(frame_flag & ctrl_three[POS_IRQ_EN]))
        else $error("irq not equal to flag and enable");
    a_irq_enable: assert property (irq |-> $past(ctrl_three[POS_IRQ_EN]))
        else $error("irq without enable");
    a_flag_clear: assert property (wr && idx == IDX_CTRL_THREE && paddr[1:0] == 2'h0 && pwdata[POS_CLEAR]
        && !sof_event |=> !frame_flag)
        else $error("flag not cleared");
    a_flag_sets: assert property (sof_event |=> frame_flag)
        else $error("flag not set on frame start");
    a_halt_wake: assert property (halt_mode |=> !wake_request)
        else $error("wake during halt");
    a_hold_strong: assert property (ctrl_two[POS_STRONG] |=> strong_drive)
        else $error("strong hold ignored");
    a_pulse_limit: assert property (pulse_cnt <= 4'h7 && pulse_cnt <= half_fb)
        else $error("drive pulse too long");
    a_blank_zero: assert property (state == ST_BLANK ##1 1'b1 |-> com_active == 8'h00)
        else $error("levels not zero in blank phase");
    a_contrast_hold: assert property (!(fb_tick && new_frame) && !halt_mode |=> $stable(contrast_out))
        else $error("contrast changed mid frame");
    a_stop_even: assert property (state == ST_ACTIVE ##1 state == ST_IDLE |-> !$past(odd_frame))
        else $error("display stopped on odd frame");

    c_sof: cover property (sof_event ##1 irq);
    c_blank: cover property (state == ST_BLANK);
    c_stop: cover property (state == ST_ACTIVE ##1 state == ST_IDLE);
endmodule

//--- logic/slcd_pkg.sv
// Purpose: Shared constants for the segment display controller.
// Assumes: Word-indexed registers on APB, byte address = index * 4.
// Notes:   Offsets below are register indexes.
package slcd_pkg;
    // ------------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL_ONE   = 6'h00;
    localparam logic [5:0] IDX_CTRL_TWO   = 6'h01;
    localparam logic [5:0] IDX_CTRL_THREE = 6'h02;
    localparam logic [5:0] IDX_CLK_SEL    = 6'h03;
    localparam logic [5:0] IDX_MASK_FIRST = 6'h04;
    localparam logic [5:0] IDX_MASK_LAST  = 6'h09;
    localparam logic [5:0] IDX_PIX_FIRST  = 6'h0C;
    localparam logic [5:0] IDX_PIX_LAST   = 6'h21;
    localparam logic [5:0] IDX_CTRL_FOUR  = 6'h2F;
    localparam int         PIX_BYTES      = 22;
    localparam int         SEG_COUNT      = 44;
    localparam logic [7:0] REG_RESET      = 8'h00;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_FLASH_SEL  = 6;   // ctrl_one [7:6]
    localparam int POS_FLASH_RATE = 3;   // ctrl_one [5:3]
    localparam int POS_MUX_RATIO  = 1;   // ctrl_one [2:1]
    localparam int POS_HALF_BIAS  = 0;   // ctrl_one [0]
    localparam int POS_PULSE_LEN  = 5;   // ctrl_two [7:5]
    localparam int POS_STRONG     = 4;   // ctrl_two [4]
    localparam int POS_CONTRAST   = 1;   // ctrl_two [3:1]
    localparam int POS_SUPPLY     = 0;   // ctrl_two [0]
    localparam int POS_DISP_EN    = 6;   // ctrl_three [6]
    localparam int POS_IRQ_EN     = 5;   // ctrl_three [5]
    localparam int POS_FLAG       = 4;   // ctrl_three [4]
    localparam int POS_CLEAR      = 3;   // ctrl_three [3]
    localparam int POS_BLANK      = 0;   // ctrl_three [2:0]
    localparam int POS_PWR_DIV    = 4;   // clock select [7:4]
    localparam int POS_FINE_DIV   = 0;   // clock select [3:0]
    localparam int POS_PAGE       = 2;   // ctrl_four [2]
    localparam int POS_EIGHTH     = 1;   // ctrl_four [1]
    localparam int POS_QUARTER    = 0;   // ctrl_four [0]
    localparam logic [7:0] CTRL3_RW_MASK = 8'h67;
    localparam logic [7:0] CTRL4_RW_MASK = 8'h07;
    localparam logic [7:0] MASK5_RW_MASK = 8'h0F;
    localparam logic [5:0] FINE_BASE     = 6'h10;
    // Bias codes driven to the analog divider
    localparam logic [1:0] BIAS_THIRD   = 2'h0;
    localparam logic [1:0] BIAS_HALF    = 2'h1;
    localparam logic [1:0] BIAS_QUARTER = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_BLANK} slcd_state_t;
endpackage

//--- tb/segment_lcd_ctrl_registers_bench.sv
// Purpose: Self-checking bench for the segment display controller.
// Assumes: APB slave answers after a wait state; fastest clock setting.
// Notes:   Frame base period is 16 cycles with both dividers at zero.
`timescale 1ns/1ns
module segment_lcd_ctrl_registers_bench;
    import slcd_pkg::*;
    logic                 pclk, presetn, psel, penable, pwrite, halt_mode, e;
    logic                 pready, pslverr, irq, wake_request, strong_drive, supply_external, display_on;
    logic [7:0]           paddr, com_active, com_seen, q, d;
    logic [31:0]          pwdata, prdata, seed;
    logic [SEG_COUNT-1:0] seg_data, seg_enable;
    logic [1:0]           bias_sel;
    logic [2:0]           contrast_out;
    logic [5:0]           ix;
    int                   num_errors, comparisons, i, n;
    slcd_ctrl u_slcd_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_mode(halt_mode), .irq(irq), .wake_request(wake_request), .com_active(com_active),
        .seg_data(seg_data), .seg_enable(seg_enable), .strong_drive(strong_drive), .bias_sel(bias_sel),
        .contrast_out(contrast_out), .supply_external(supply_external), .display_on(display_on));
    slcd_glass_model u_slcd_glass_model(.pclk(pclk), .presetn(presetn), .com_active(com_active),
        .com_seen(com_seen));
    // --------
    // Helpers
    // --------
    task automatic apb(input logic wr, input logic [5:0] x, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= {x, 2'b00}; pwdata <= {24'h000000, wd}; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge pclk);
    endtask
    function automatic logic [7:0] rw_mask(input logic [5:0] x);
        return x == IDX_CTRL_THREE ? CTRL3_RW_MASK : x == IDX_CTRL_FOUR ? CTRL4_RW_MASK :
               x == IDX_MASK_LAST ? MASK5_RW_MASK : 8'hFF;
    endfunction
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end
    // --------
    // Main sequence
    // --------
    initial begin
        seed = 32'h70FE; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; halt_mode = 1'b0; num_errors = 0; comparisons = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then random write and read back of every control and pin mask register
        for (n = 0; n < 3; n++) for (i = 0; i < 11; i++) begin
            ix = (i == 10) ? IDX_CTRL_FOUR : i[5:0];
            d = 8'($random(seed));
            if (ix == IDX_CTRL_THREE) d = d & 8'h2F;
            if (n > 0) apb(1'b1, ix, d);
            apb(1'b0, ix, 8'h00);
            chk("reg read", q, n > 0 ? d & rw_mask(ix) : REG_RESET);
            chk("reg err", e, 1'b0);
        end
        apb(1'b1, 6'h0A, 8'h5A);
        chk("unmapped err", e, 1'b1);
        // Bias codes, supply, hold and pin masks
        for (i = 0; i < 3; i++) begin
            apb(1'b1, IDX_CTRL_ONE, {7'h03, i == 1});
            apb(1'b1, IDX_CTRL_FOUR, {7'h00, i == 2});
            settle();
            chk("bias", bias_sel, i == 2 ? BIAS_QUARTER : i == 1 ? BIAS_HALF : BIAS_THIRD);
        end
        apb(1'b1, IDX_CTRL_TWO, 8'h11);
        apb(1'b1, IDX_MASK_FIRST, 8'hA5);
        settle();
        chk("hold", strong_drive, 1'b1);
        chk("supply", supply_external, 1'b1);
        chk("pin mask", seg_enable[7:0], 8'hA5);
        apb(1'b1, IDX_CTRL_TWO, 8'h0A);
        apb(1'b1, IDX_CLK_SEL, 8'h00);
        settle();
        chk("contrast idle", contrast_out, 3'h0);
        // Row of the last common, bits 7:0, page 0
        apb(1'b1, IDX_PIX_FIRST + 6'h0A, 8'hF0);
        apb(1'b1, IDX_PIX_FIRST + 6'h0B, 8'h3C);
        // Run frames with one blank phase until the flag rises on the last common
        apb(1'b1, IDX_CTRL_THREE, 8'h69);
        n = 0;
        do begin apb(1'b0, IDX_CTRL_THREE, 8'h00); n++; end while (q[POS_FLAG] !== 1'b1 && n < 300);
        settle();
        chk("flag", q[POS_FLAG], 1'b1);
        chk("last common", com_active, 8'h08);
        chk("contrast", contrast_out, 3'h5);
        chk("seg row", seg_data[7:0], 8'h85);
        chk("irq", irq, 1'b1);
        chk("wake", wake_request, 1'b1);
        @(posedge pclk);
        halt_mode <= 1'b1;
        settle();
        chk("halt wake", wake_request, 1'b0);
        @(posedge pclk);
        halt_mode <= 1'b0;
        // Clear flag and disable early in a frame: runs on to the next even frame end
        while (com_active !== 8'h01) @(negedge pclk);
        apb(1'b1, IDX_CTRL_THREE, 8'h29);
        settle();
        chk("still on", display_on, 1'b1);
        chk("irq cleared", irq, 1'b0);
        repeat (200) @(negedge pclk);
        chk("off", display_on, 1'b0);
        chk("commons", com_seen, 8'h0F);
        apb(1'b0, IDX_CTRL_THREE, 8'h00);
        chk("flag again", q, 8'h31);
        apb(1'b1, IDX_CTRL_THREE, 8'h29);
        apb(1'b0, IDX_CTRL_THREE, 8'h00);
        chk("cleared", q, 8'h21);
        chk("irq low", irq, 1'b0);
        wrap_up();
    end
endmodule

//--- tb/slcd_glass_model.sv
// Purpose: Passive glass panel seen from the common drivers.
// Assumes: One-hot common selects, zero while idle or blank.
// Notes:   Remembers every common that was ever driven.
`timescale 1ns/1ns
module slcd_glass_model
    import slcd_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Panel lines
    input  wire logic [7:0] com_active,
    // Observation
    output logic      [7:0] com_seen
);
    // Accumulate lit commons
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_seen <= 8'h00;
        end else begin
            com_seen <= com_seen | com_active;
        end
    end
endmodule
